// ### logic/gain_offset_regs.svh
`ifndef GAIN_OFFSET_REGS_SVH
`define GAIN_OFFSET_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_GAIN_SELECT    8'h00
`define OFS_CURRENT_OFFSET 8'h04
`define OFS_VOLTAGE_OFFSET 8'h08
`define OFS_FILTER_CTRL    8'h0C
`define OFS_WAVEFORM       8'h10
`define OFS_ENERGY         8'h14

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_GAIN_SELECT    8'h00
`define RST_CURRENT_OFFSET 6'h00
`define RST_VOLTAGE_OFFSET 6'h00
`define RST_FILTER_CTRL    2'h0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define POS_INTEG_EN       7
`define POS_HPF_EN         0
`define POS_WAVE_SEL       1

// ----------------------------------------------------------------------
// Offset step weights per gain, hundredths of a millivolt
// ----------------------------------------------------------------------
`define STEP_GAIN1         8'hA1
`define STEP_GAIN2         8'h77
`define STEP_GAIN4         8'h61
`define STEP_GAIN8         8'h54
`define STEP_GAIN16        8'h4D

// ----------------------------------------------------------------------
// Filter time constants, as right shifts
// ----------------------------------------------------------------------
`define HPF_SHIFT          10
`define LEAK_SHIFT         12
`define LPF_SHIFT          8

`endif

// ### logic/gain_offset_pkg.sv
package gain_offset_pkg;

  // Gain register layout, upper field first.
  typedef struct packed {
    logic [2:0] voltage_gain;
    logic [1:0] current_range;
    logic [2:0] current_gain;
  } gain_cfg_t;

  // Sign-and-magnitude offset correction value.
  typedef struct packed {
    logic       sign;
    logic [4:0] mag;
  } offset_sm_t;

  // Full-scale range of the current channel converter.
  typedef enum logic [1:0] {
    RANGE_HALF,
    RANGE_QUARTER,
    RANGE_EIGHTH
  } range_sel_t;

endpackage

// ### logic/offset_corrector.sv
`timescale 1ns/1ps
`include "gain_offset_regs.svh"

module offset_corrector #(
  parameter int W            = 16,
  parameter bit SUBTRACT     = 1'b0,
  parameter int WEIGHT_SHIFT = 7
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  // Sample in
  input  wire logic                        in_valid,
  input  wire logic signed [W-1:0]         in_sample,
  // Configuration
  input  wire gain_offset_pkg::offset_sm_t corr,
  input  wire logic [2:0]                  gain_idx,
  // Sample out
  output logic                             out_valid,
  output logic signed [W-1:0]              out_sample
);
  import gain_offset_pkg::*;

  logic [7:0]          weight;
  logic [12:0]         scaled;
  logic signed [W+1:0] term;
  logic signed [W+1:0] sum;

  // ----------------------------------------------------------------------
  // Step weight shrinks as gain grows
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (gain_idx)
      3'h1:    weight = `STEP_GAIN2;
      3'h2:    weight = `STEP_GAIN4;
      3'h3:    weight = `STEP_GAIN8;
      3'h4:    weight = `STEP_GAIN16;
      default: weight = `STEP_GAIN1;
    endcase
  end

  // Magnitude is five bits, so the span is plus or minus thirty-one.
  assign scaled = 13'(corr.mag * weight) >> WEIGHT_SHIFT;

  // Current adds the signed value, voltage subtracts it.
  always_comb begin
    term = $signed({{(W-11){1'b0}}, scaled});
    if (corr.sign ^ SUBTRACT) begin
      term = -term;
    end
    sum = $signed({{2{in_sample[W-1]}}, in_sample}) + term;
  end

  // ----------------------------------------------------------------------
  // Saturating output stage
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid  <= 1'b0;
      out_sample <= '0;
    end else if (ce) begin
      out_valid <= in_valid;
      if (in_valid) begin
        if (sum > $signed({3'b000, {(W-1){1'b1}}})) begin
          out_sample <= {1'b0, {(W-1){1'b1}}};
        end else if (sum < $signed({3'b111, {(W-1){1'b0}}})) begin
          out_sample <= {1'b1, {(W-1){1'b0}}};
        end else begin
          out_sample <= sum[W-1:0];
        end
      end
    end
  end

endmodule

// ### logic/energy_accum.sv
`timescale 1ns/1ps
`include "gain_offset_regs.svh"

module energy_accum #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // Channel samples
  input  wire logic                in_valid,
  input  wire logic signed [W-1:0] cur_sample,
  input  wire logic signed [W-1:0] volt_sample,
  // Accumulated energy
  output logic [23:0]              active_energy_accum
);
  import gain_offset_pkg::*;

  logic signed [2*W-1:0] product;
  logic signed [2*W-1:0] power_lowpass;
  logic signed [2*W-1:0] lp_step;

  assign product = cur_sample * volt_sample;
  assign lp_step = (product - power_lowpass) >>> `LPF_SHIFT;

  // ----------------------------------------------------------------------
  // Low-pass of instantaneous power
  // ----------------------------------------------------------------------
  // The line-frequency ripple left by the low-pass averages out below.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_lowpass <= '0;
    end else if (ce && in_valid) begin
      power_lowpass <= power_lowpass + lp_step;
    end
  end

  // ----------------------------------------------------------------------
  // 24-bit energy integration, wraps on overflow
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_energy_accum <= 24'h000000;
    end else if (ce && in_valid) begin
      active_energy_accum <= active_energy_accum
                           + power_lowpass[2*W-1 -: 24];
    end
  end

endmodule

// ### logic/channel_gain_offset_config.sv
`timescale 1ns/1ps
`include "gain_offset_regs.svh"

// Function
// - Current gain 1..16 comes from gain register bits 2:0.
// - Voltage gain 1..16 comes from gain register bits 7:5.
// - Gain bits 4:3 pick current range: half, quarter or eighth volt.
// - Offset corrections are six-bit sign-and-magnitude values.
// - Offset magnitude spans zero to thirty-one either way.
// - Offset step weight falls from gain one to gain sixteen.
// - Current adds the correction, voltage subtracts it: opposite polarity.
// - Waveform register returns the selected channel's residual sample.
// - Enabled current high-pass removes its DC offset before the product.
// - Low-passed power integrates into a 24-bit energy accumulator.
// - Integrator is off at reset, on via current offset register MSB.
module channel_gain_offset_config #(
  parameter int W = 16
) (
  // Clock, enable and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Raw converter samples
  input  wire logic                sample_valid,
  input  wire logic signed [W-1:0] cur_raw,
  input  wire logic signed [W-1:0] volt_raw,
  // Front-end configuration
  output logic [4:0]               cur_pga_gain,
  output logic [4:0]               volt_pga_gain,
  output gain_offset_pkg::range_sel_t cur_range,
  // Processed samples and energy
  output logic                     proc_valid,
  output logic signed [W-1:0]      cur_proc,
  output logic signed [W-1:0]      volt_proc,
  output logic [23:0]              active_energy_accum
);
  import gain_offset_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  gain_cfg_t           gain_q;
  offset_sm_t          cur_ofs_q;
  offset_sm_t          volt_ofs_q;
  logic                integ_en_q;
  logic                hpf_en_q;
  logic                wave_sel_q;

  logic                wr_en;
  logic                mapped;
  logic [2:0]          cur_gidx;
  logic [2:0]          volt_gidx;
  logic                corr_valid;
  logic signed [W-1:0] cur_corr;
  logic signed [W-1:0] volt_corr;
  logic signed [W+7:0] integ_q;
  logic signed [W+7:0] dc_q;
  logic signed [W-1:0] integ_out;
  logic signed [W-1:0] chain_in;
  logic signed [W-1:0] dc_est;
  logic signed [W:0]   hp_diff;
  logic signed [W+7:0] chain_ext;

  // Gain code to shift; undefined codes fall back to unity.
  function automatic logic [2:0] gain_index(input logic [2:0] code);
    gain_index = (code <= 3'h4) ? code : 3'h0;
  endfunction

  assign cur_gidx  = gain_index(gain_q.current_gain);
  assign volt_gidx = gain_index(gain_q.voltage_gain);

  // One-hot gain to the amplifiers, bit n meaning gain two to the n.
  assign cur_pga_gain  = 5'(5'h01 << cur_gidx);
  assign volt_pga_gain = 5'(5'h01 << volt_gidx);

  // ----------------------------------------------------------------------
  // Range decode
  // ----------------------------------------------------------------------
  // The fourth code has no defined range, so it keeps the widest one.
  always_comb begin
    unique case (gain_q.current_range)
      2'h1:    cur_range = RANGE_QUARTER;
      2'h2:    cur_range = RANGE_EIGHTH;
      default: cur_range = RANGE_HALF;
    endcase
  end

  // ----------------------------------------------------------------------
  // APB decode; the slave never waits
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (paddr)
      `OFS_GAIN_SELECT,
      `OFS_CURRENT_OFFSET,
      `OFS_VOLTAGE_OFFSET,
      `OFS_FILTER_CTRL,
      `OFS_WAVEFORM,
      `OFS_ENERGY: mapped = 1'b1;
      default:     mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && ce;

  // Read mux; unmapped or idle reads give zero.
  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      unique case (paddr)
        `OFS_GAIN_SELECT:    prdata = {24'h000000, gain_q};
        `OFS_CURRENT_OFFSET: prdata = {24'h000000, integ_en_q,
                                       1'b0, cur_ofs_q};
        `OFS_VOLTAGE_OFFSET: prdata = {26'h0, volt_ofs_q};
        `OFS_FILTER_CTRL:    prdata = {30'h0, wave_sel_q,
                                       hpf_en_q};
        `OFS_WAVEFORM:       prdata = wave_sel_q
                               ? {{(32-W){volt_proc[W-1]}}, volt_proc}
                               : {{(32-W){cur_proc[W-1]}}, cur_proc};
        `OFS_ENERGY:         prdata = {8'h00, active_energy_accum};
        default:             prdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_q <= `RST_GAIN_SELECT;
    end else if (wr_en && paddr == `OFS_GAIN_SELECT) begin
      gain_q <= pwdata[7:0];
    end
  end

  // Integrator enable shares the current offset register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ofs_q  <= `RST_CURRENT_OFFSET;
      integ_en_q <= 1'b0;
    end else if (wr_en && paddr == `OFS_CURRENT_OFFSET) begin
      cur_ofs_q  <= pwdata[5:0];
      integ_en_q <= pwdata[`POS_INTEG_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_ofs_q <= `RST_VOLTAGE_OFFSET;
    end else if (wr_en && paddr == `OFS_VOLTAGE_OFFSET) begin
      volt_ofs_q <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {wave_sel_q, hpf_en_q} <= `RST_FILTER_CTRL;
    end else if (wr_en && paddr == `OFS_FILTER_CTRL) begin
      hpf_en_q   <= pwdata[`POS_HPF_EN];
      wave_sel_q <= pwdata[`POS_WAVE_SEL];
    end
  end

  // ----------------------------------------------------------------------
  // Offset correction, one per channel
  // ----------------------------------------------------------------------
  offset_corrector #(
    .W        (W),
    .SUBTRACT (1'b0)
  ) u_cur_corr (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .in_valid   (sample_valid),
    .in_sample  (cur_raw),
    .corr       (cur_ofs_q),
    .gain_idx   (cur_gidx),
    .out_valid  (corr_valid),
    .out_sample (cur_corr)
  );

  offset_corrector #(
    .W        (W),
    .SUBTRACT (1'b1)
  ) u_volt_corr (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .in_valid   (sample_valid),
    .in_sample  (volt_raw),
    .corr       (volt_ofs_q),
    .gain_idx   (volt_gidx),
    .out_valid  (),
    .out_sample (volt_corr)
  );

  // ----------------------------------------------------------------------
  // Current integrator, leaky to keep DC from winding it up
  // ----------------------------------------------------------------------
  // The leak costs a little gain at very low frequency; it is the price
  // of never saturating on a residual offset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_q <= '0;
    end else if (ce && corr_valid) begin
      if (integ_en_q) begin
        integ_q <= integ_q - (integ_q >>> `LEAK_SHIFT)
                 + {{8{cur_corr[W-1]}}, cur_corr};
      end else begin
        integ_q <= '0;
      end
    end
  end

  assign integ_out = integ_q[W+7:8];
  assign chain_in  = integ_en_q ? integ_out : cur_corr;
  assign chain_ext = {chain_in, 8'h00};
  assign dc_est    = dc_q[W+7:8];
  assign hp_diff   = {chain_in[W-1], chain_in} - {dc_est[W-1], dc_est};

  // ----------------------------------------------------------------------
  // Current high-pass: track DC and subtract it
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_q <= '0;
    end else if (ce && corr_valid) begin
      if (hpf_en_q) begin
        dc_q <= dc_q + ((chain_ext - dc_q) >>> `HPF_SHIFT);
      end else begin
        dc_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Processed sample stage
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_valid <= 1'b0;
      cur_proc   <= '0;
      volt_proc  <= '0;
    end else if (ce) begin
      proc_valid <= corr_valid;
      if (corr_valid) begin
        cur_proc  <= hpf_en_q ? hp_diff[W-1:0] : chain_in;
        volt_proc <= volt_corr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power and energy
  // ----------------------------------------------------------------------
  energy_accum #(
    .W (W)
  ) u_energy (
    .pclk                (pclk),
    .presetn             (presetn),
    .ce                  (ce),
    .in_valid            (proc_valid),
    .cur_sample          (cur_proc),
    .volt_sample         (volt_proc),
    .active_energy_accum (active_energy_accum)
  );

endmodule

// ### verif/gain_cfg_props.sv
`timescale 1ns/1ps
`include "gain_offset_regs.svh"

module gain_cfg_props
  import gain_offset_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                ce,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  // Datapath
  input wire logic                sample_valid,
  input wire logic                proc_valid,
  input wire logic signed [W-1:0] cur_proc,
  input wire logic signed [W-1:0] volt_proc,
  input wire logic [4:0]          cur_pga_gain,
  input wire logic [4:0]          volt_pga_gain,
  input wire range_sel_t          cur_range,
  input wire logic [23:0]         active_energy_accum
);
  // ---------------------------------------------------------------
  // Shadow registers
  // ---------------------------------------------------------------
  logic [7:0] gain_q;
  logic [7:0] cofs_q;
  logic [5:0] vofs_q;
  logic       wsel_q;
  logic       wr_ok;
  logic       rd_acc;

  // A write lands only when the clock enable is high.
  assign wr_ok = psel && penable && pwrite && ce && pready;
  assign rd_acc = psel && penable && !pwrite;

  // Shadows mirror what software wrote, masked to the kept bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_q <= 8'h00;
      cofs_q <= 8'h00;
      vofs_q <= 6'h00;
      wsel_q <= 1'b0;
    end else if (wr_ok) begin
      case (paddr)
        `OFS_GAIN_SELECT:    gain_q <= pwdata[7:0];
        `OFS_CURRENT_OFFSET: cofs_q <= {pwdata[7], 1'b0, pwdata[5:0]};
        `OFS_VOLTAGE_OFFSET: vofs_q <= pwdata[5:0];
        `OFS_FILTER_CTRL:    wsel_q <= pwdata[`POS_WAVE_SEL];
        default: ;
      endcase
    end
  end

  // Codes above four fall back to unity gain.
  function automatic logic [4:0] hot(input logic [2:0] c);
    return (c < 3'h5) ? (5'h01 << c) : 5'h01;
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cur_gain_map: assert property (
    cur_pga_gain == hot(gain_q[2:0])) else $error("current gain wrong");
  a_volt_gain_map: assert property (
    volt_pga_gain == hot(gain_q[7:5])) else $error("voltage gain wrong");
  a_unused_unity: assert property (
    wr_ok && paddr == `OFS_GAIN_SELECT && pwdata[2:0] > 3'h4
    |=> (cur_pga_gain == 5'h01) [*2]) else $error("unused code not unity");
  a_range_map: assert property (
    cur_range == ((gain_q[4:3] == 2'h3) ? RANGE_HALF
                  : range_sel_t'(gain_q[4:3]))) else $error("range wrong");
  a_proc_latency: assert property (
    sample_valid && ce ##1 ce |=> proc_valid) else $error("proc late");
  a_proc_cause: assert property (
    proc_valid |-> $past(sample_valid, 2)) else $error("proc unprompted");
  a_wave_read: assert property (
    rd_acc && paddr == `OFS_WAVEFORM |-> prdata == (wsel_q ?
    32'(volt_proc) : 32'(cur_proc))) else $error("waveform read wrong");
  a_integ_read: assert property (
    rd_acc && paddr == `OFS_CURRENT_OFFSET |-> prdata == {24'h0, cofs_q})
    else $error("current offset read wrong");
  a_volt_ofs_read: assert property (
    rd_acc && paddr == `OFS_VOLTAGE_OFFSET |-> prdata == {26'h0, vofs_q})
    else $error("voltage offset read wrong");
  a_energy_hold: assert property (
    !$past(proc_valid) |-> $stable(active_energy_accum))
    else $error("energy moved without power");
endmodule

bind channel_gain_offset_config gain_cfg_props #(.W(W)) u_gain_cfg_props (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .sample_valid(sample_valid),
  .proc_valid(proc_valid), .cur_proc(cur_proc), .volt_proc(volt_proc),
  .cur_pga_gain(cur_pga_gain), .volt_pga_gain(volt_pga_gain),
  .cur_range(cur_range), .active_energy_accum(active_energy_accum));

// ### verif/tb.sv
`timescale 1ns/1ps
`include "gain_offset_regs.svh"

module tb;
  import gain_offset_pkg::*;
  // ---------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------
  logic              pclk, presetn, ce, psel, penable, pwrite;
  logic              sample_valid, pready, pslverr, proc_valid;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, q;
  logic signed [15:0] cur_raw, volt_raw, cur_proc, volt_proc;
  logic [4:0]        cur_pga_gain, volt_pga_gain;
  range_sel_t        cur_range;
  logic [23:0]       active_energy_accum;
  logic              e;
  int                err_total, total_checks, t;
  int                wt [5] = '{`STEP_GAIN1, `STEP_GAIN2, `STEP_GAIN4,
                                `STEP_GAIN8, `STEP_GAIN16};
  typedef struct packed {
    logic [7:0] g;
    logic [4:0] cg;
    logic [4:0] vg;
    logic [1:0] rg;
  } row_t;
  row_t rows [8] = '{'{8'hE0, 5'h01, 5'h01, 2'h0},
    '{8'hC9, 5'h02, 5'h01, 2'h1}, '{8'hB2, 5'h04, 5'h01, 2'h2},
    '{8'h9B, 5'h08, 5'h10, 2'h0}, '{8'h64, 5'h10, 5'h08, 2'h0},
    '{8'h4D, 5'h01, 5'h04, 2'h1}, '{8'h36, 5'h01, 5'h02, 2'h2},
    '{8'h1F, 5'h01, 5'h01, 2'h0}};

  channel_gain_offset_config u_channel_gain_offset_config (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .cur_raw(cur_raw), .volt_raw(volt_raw),
    .cur_pga_gain(cur_pga_gain), .volt_pga_gain(volt_pga_gain),
    .cur_range(cur_range), .proc_valid(proc_valid), .cur_proc(cur_proc),
    .volt_proc(volt_proc), .active_energy_accum(active_energy_accum));

  // Free-running bus clock at 50 MHz.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, exp);
    total_checks++;
    if (s !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, s);
    end
  endtask

  // A wait that runs out ends the run rather than hanging it.
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("[ERR] handshake expected done seen timeout");
      tally_and_finish();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    guard(n, 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic smp(input logic signed [15:0] c, v);
    int n;
    @(posedge pclk);
    sample_valid <= 1'b1;
    cur_raw <= c;
    volt_raw <= v;
    @(posedge pclk);
    sample_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (proc_valid !== 1'b1 && n < 10);
    guard(n, 10);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, ce, psel, penable, pwrite, sample_valid} = 6'h00;
    {paddr, pwdata, cur_raw, volt_raw} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ce <= 1'b1;
    apb(1'b0, `OFS_CURRENT_OFFSET, 32'h0);
    chk("offset reset", q, 32'h0);
    chk("offset err", e, 1'b0);
    // Gain and range decode for every code.
    foreach (rows[i]) begin
      apb(1'b1, `OFS_GAIN_SELECT, {24'h0, rows[i].g});
      apb(1'b0, `OFS_GAIN_SELECT, 32'h0);
      chk("gain reg", q, {24'h0, rows[i].g});
      chk("cur gain", cur_pga_gain, rows[i].cg);
      chk("volt gain", volt_pga_gain, rows[i].vg);
      chk("range", cur_range, rows[i].rg);
    end
    $display("test gain_decode done");
    // Full-scale correction at each gain, both signs.
    for (int g = 0; g < 5; g++) begin
      for (int s = 0; s < 2; s++) begin
        t = (31 * wt[g]) >>> 7;
        if (s == 1) t = -t;
        apb(1'b1, `OFS_GAIN_SELECT, {24'h0, 3'(g), 2'h0, 3'(g)});
        apb(1'b1, `OFS_CURRENT_OFFSET, {26'h0, 1'(s), 5'h1F});
        apb(1'b1, `OFS_VOLTAGE_OFFSET, {26'h0, 1'(s), 5'h1F});
        apb(1'b1, `OFS_FILTER_CTRL, {30'h0, 1'(s), 1'b0});
        smp(16'sh0064, -16'sh0064);
        chk("cur_proc", cur_proc, 100 + t);
        chk("volt_proc", volt_proc, -100 - t);
        apb(1'b0, `OFS_WAVEFORM, 32'h0);
        chk("waveform", q, (s == 1) ? -100 - t : 100 + t);
      end
    end
    $display("test offset_correct done");
    // Oversized writes keep only the documented bits.
    apb(1'b1, `OFS_VOLTAGE_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, `OFS_VOLTAGE_OFFSET, 32'h0);
    chk("volt offset mask", q, 32'h3F);
    apb(1'b1, `OFS_CURRENT_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, `OFS_CURRENT_OFFSET, 32'h0);
    chk("integ enable", q, 32'hBF);
    $display("test field_masks done");
    // Constant input decays away once the high-pass filter is on.
    apb(1'b1, `OFS_CURRENT_OFFSET, 32'h0);
    apb(1'b1, `OFS_GAIN_SELECT, 32'h0);
    apb(1'b1, `OFS_FILTER_CTRL, 32'h1);
    @(posedge pclk);
    sample_valid <= 1'b1;
    cur_raw <= 16'sh0064;
    repeat (8000) @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("hpf residual", (cur_proc > -16'sh0008 && cur_proc < 16'sh0008), 1);
    $display("test highpass done");
    // Integrator on: the first sample shows the cleared state, the second
    // shows one step scaled down by 256.
    apb(1'b1, `OFS_FILTER_CTRL, 32'h0);
    apb(1'b1, `OFS_CURRENT_OFFSET, 32'h80);
    smp(16'sh1000, 16'sh0000);
    smp(16'sh1000, 16'sh0000);
    chk("integrator", cur_proc, 32'h10);
    apb(1'b1, `OFS_CURRENT_OFFSET, 32'h0);
    $display("test integrator done");
    // Refusals: unmapped address and frozen clock enable.
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", q, 32'h0);
    @(posedge pclk);
    ce <= 1'b0;
    apb(1'b1, `OFS_GAIN_SELECT, 32'h21);
    ce <= 1'b1;
    apb(1'b0, `OFS_GAIN_SELECT, 32'h0);
    chk("ce write drop", q, 32'h0);
    $display("test refusals done");
    // Reset in mid-run returns the current gain to unity.
    chk("energy moved", active_energy_accum != 24'h0, 1);
    apb(1'b1, `OFS_GAIN_SELECT, 32'h9B);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset gain", cur_pga_gain, 5'h01);
    chk("reset range", cur_range, RANGE_HALF);
    chk("reset energy", active_energy_accum, 24'h0);
    $display("test midrun_reset done");
    tally_and_finish();
  end
endmodule
